// ==== rtl/adcseq_pkg.sv ====
// Purpose: shared constants and types of the channel list sequencer
// Assumes: classic wishbone slave with 32-bit data and byte addresses
// Notes:   entry word layout, register map, reset values, pacing figures
package adcseq_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS  = 8'h00;
   localparam logic [7:0] LAST_OFS  = 8'h04;
   localparam logic [7:0] DIV_OFS   = 8'h08;
   localparam logic [7:0] LPTR_OFS  = 8'h0c;
   localparam logic [7:0] LDATA_OFS = 8'h10;
   localparam logic [7:0] STAT_OFS  = 8'h14;
   localparam logic [7:0] SMP_OFS   = 8'h18;
   localparam logic [7:0] CMD_OFS   = 8'h1c;
   // control register bit positions
   localparam int C_DIFF    = 0;
   localparam int C_BIP     = 1;
   localparam int C_EXT     = 2;
   localparam int C_DYN     = 3;
   localparam int C_TRIG    = 4;
   localparam int C_PASS_LO = 8;
   localparam logic [15:0] CTRL_MASK = 16'hff1f;
   // command and status bit positions
   localparam int K_GO      = 0;
   localparam int K_STOP    = 1;
   localparam int S_RUN     = 0;
   localparam int S_WAIT    = 1;
   localparam int S_OVR     = 2;
   localparam int S_CERR    = 3;
   localparam int S_IDX_LO  = 16;
   // list entry word layout
   localparam int CH_W      = 6;
   localparam int E_CH_LO   = 0;
   localparam int E_GAIN_LO = 6;
   localparam int E_INH     = 8;
   localparam int E_DYN_LO  = 9;
   localparam int ENTRY_W   = 11;
   localparam int SMP_W     = 16;
   localparam logic [CH_W-1:0] DIG_CH   = 6'h20;
   localparam logic [CH_W-1:0] SE_MAX   = 6'h1f;
   localparam logic [CH_W-1:0] DIFF_MAX = 6'h0f;
   // reset values
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [9:0]  LAST_RST = 10'h000;
   localparam logic [23:0] DIV_RST  = 24'h000014;
   // pacing time base against the system clock
   localparam int TB_HZ   = 20_000_000;
   localparam int CLK_HZ  = 10_000_000;
   localparam int TB_STEP = TB_HZ / CLK_HZ;
   typedef enum {ST_IDLE, ST_TICK, ST_CONV, ST_RETRIG} adcseq_state_e;
endpackage : adcseq_pkg

// ==== rtl/adcseq_list_if.sv ====
// Purpose: bundle between sequencer and its channel list memory
// Assumes: one write port, one registered read port
// Notes:   read data belongs to the address of the previous cycle
`timescale 1ns/1ps
interface adcseq_list_if #(
   parameter int AW = 10
);
   logic                           we;
   logic [AW-1:0]                  waddr;
   logic [AW-1:0]                  raddr;
   logic [adcseq_pkg::ENTRY_W-1:0] wdata;
   logic [adcseq_pkg::ENTRY_W-1:0] rdata;
   modport ctl (output we, waddr, wdata, raddr, input rdata);
   modport ram (input we, waddr, wdata, raddr, output rdata);
endinterface : adcseq_list_if

// ==== rtl/adcseq_list_ram.sv ====
// Purpose: channel list storage, one word per entry
// Assumes: depth fits the address width of the bundle
// Notes:   read during write of the same word returns the old word
`timescale 1ns/1ps
module adcseq_list_ram #(
   parameter int DEPTH = 1024
) (
   // clock
   input wire logic      clk_i,
   // list port
   adcseq_list_if.ram    lst
);
   logic [adcseq_pkg::ENTRY_W-1:0] mem [DEPTH];

   // no reset on the array: contents are undefined until written
   always_ff @(posedge clk_i) begin
      if (lst.we) begin
         mem[lst.waddr] <= lst.wdata;
      end
      lst.rdata <= mem[lst.raddr];
   end
endmodule : adcseq_list_ram

// ==== rtl/adcseq_pacer.sv ====
// Purpose: sample clock, internal divider or external input
// Assumes: external clock input is synchronous to clk_i
// Notes:   divider counts time base units, two per system clock
`timescale 1ns/1ps
module adcseq_pacer #(
   parameter int DIV_W = 24
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // control
   input  wire logic             run_i,
   input  wire logic             ext_sel_i,
   input  wire logic [DIV_W-1:0] div_i,
   input  wire logic             ext_clk_i,
   // outputs
   output logic                  tick_o,
   output logic                  pace_n_o
);
   localparam logic [DIV_W-1:0] STEP = DIV_W'(adcseq_pkg::TB_STEP);
   logic [DIV_W-1:0] cnt_r;
   logic             ext_q_r;

   // pulse low for one cycle; never twice in a row, so it always falls
   wire expire   = run_i & ~ext_sel_i & (cnt_r <= STEP) & pace_n_o;
   wire ext_fall = run_i & ext_sel_i & ext_q_r & ~ext_clk_i;

   // conversion starts on the falling edge of either source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r    <= DIV_W'(adcseq_pkg::DIV_RST);
         ext_q_r  <= 1'b0;
         pace_n_o <= 1'b1;
         tick_o   <= 1'b0;
      end else begin
         ext_q_r  <= ext_clk_i;
         pace_n_o <= ~expire;
         tick_o   <= expire | ext_fall;
         if (!run_i || expire) begin
            cnt_r <= div_i;
         end else begin
            cnt_r <= cnt_r - STEP;
         end
      end
   end
endmodule : adcseq_pacer

// ==== rtl/adcseq_top.sv ====
// Purpose: channel list sequencer of a 16-bit analog input subsystem
// Assumes: classic wishbone register bus, converter answers with done
// Notes:   one sample clock tick takes exactly one list entry
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps

// How it works
// - results always leave as fixed 16-bit words, no width setting exists
// - channels 0..31 single-ended or 0..15 differential are accepted
// - list memory holds up to 1024 entries, each naming a channel
// - entries are sampled in order from first to last
// - any order, single channel and repeated channels are all allowed
// - triggered scan repeats the whole list 1..256 times per trigger
// - per-entry inhibit converts the channel but drops the result
// - channel 32 captures all 16 digital lines as one sample
// - digital entry may sit anywhere, repeat, and is paced like analog
// - an enable lets list entries drive the two dynamic outputs
// - dynamic outputs start at zero, reset leaves them untouched
// - entry bit 9 drives line 0, bit 10 drives line 1, one is high
// - one unipolar or bipolar range bit serves all channels
// - each entry carries a gain code for 1, 2, 4 or 8
// - sample clock is a 24-bit divider or the external clock input
// - one sample clock tick paces exactly one list entry
// - divider runs on a 20 MHz time base, start on low-going pulse
// - external clock starts a conversion on its falling edge
// - continuous scan wraps to the first entry until stopped
module adcseq_top #(
   parameter int ADR_W = 8,
   parameter int LST_W = 10,
   parameter int DEPTH = 1024,
   parameter int DIV_W = 24
) (
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // wishbone slave
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [ADR_W-1:0]       wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   // converter front end
   output logic                        conv_start_o,
   output logic      [4:0]             conv_chan_o,
   output logic      [1:0]             conv_gain_o,
   output logic                        conv_diff_o,
   output logic                        conv_bip_o,
   input  wire logic [15:0]            conv_data_i,
   input  wire logic                   conv_done_i,
   // digital lines and sample clock pins
   input  wire logic [15:0]            dio_i,
   input  wire logic                   ext_clk_i,
   output logic                        pace_n_o,
   output logic      [1:0]             dyn_o,
   // sample stream and state
   output logic                        smp_valid_o,
   output logic      [15:0]            smp_data_o,
   output logic      [5:0]             smp_chan_o,
   output logic                        run_o
);
   localparam int CW = adcseq_pkg::CH_W;
   localparam int EW = adcseq_pkg::ENTRY_W;

   // merge write data into an old word under the byte enables
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // channel legality depends on the subsystem-wide channel type
   function automatic logic chan_ok(input logic [CW-1:0] ch,
                                    input logic          diff);
      return (ch == adcseq_pkg::DIG_CH) ||
             (diff ? (ch <= adcseq_pkg::DIFF_MAX)
                   : (ch <= adcseq_pkg::SE_MAX));
   endfunction : chan_ok

   // registers
   logic [15:0]              ctrl_r;
   logic [LST_W-1:0]         last_r;
   logic [DIV_W-1:0]         div_r;
   logic [LST_W-1:0]         lptr_r;
   logic                     ack_r;
   logic [31:0]              dat_r;
   adcseq_pkg::adcseq_state_e state_r;
   adcseq_pkg::adcseq_state_e state_nxt;
   logic [LST_W-1:0]         idx_r;
   logic [LST_W-1:0]         idx_nxt;
   logic [7:0]               pass_r;
   logic [7:0]               pass_nxt;
   logic [EW-1:0]            cur_r;
   logic                     ovr_r;
   logic                     cerr_r;
   logic                     start_r;
   logic                     valid_r;
   logic [15:0]              data_r;
   logic [CW-1:0]            chan_r;
   logic [1:0]               dyn_r = 2'b00;
   logic                     tick;
   logic                     run_r;

   adcseq_list_if #(.AW(LST_W)) lst ();

   // bus decode
   wire              bus_req  = wb_cyc_i & wb_stb_i & ~ack_r;
   wire              bus_wr   = bus_req & wb_we_i;
   wire [7:0]        ofs      = {wb_adr_i[7:2], 2'b00};
   wire              hit_ctrl = ofs == adcseq_pkg::CTRL_OFS;
   wire              hit_last = ofs == adcseq_pkg::LAST_OFS;
   wire              hit_div  = ofs == adcseq_pkg::DIV_OFS;
   wire              hit_lptr = ofs == adcseq_pkg::LPTR_OFS;
   wire              hit_ldat = ofs == adcseq_pkg::LDATA_OFS;
   wire              hit_stat = ofs == adcseq_pkg::STAT_OFS;
   wire              hit_smp  = ofs == adcseq_pkg::SMP_OFS;
   wire              hit_cmd  = ofs == adcseq_pkg::CMD_OFS;
   wire [31:0]       wmerge   = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
   wire              cmd_go   = bus_wr & hit_cmd &
                                wmerge[adcseq_pkg::K_GO];
   wire              cmd_stop = bus_wr & hit_cmd &
                                wmerge[adcseq_pkg::K_STOP];
   wire              clr_ovr  = bus_wr & hit_stat &
                                wmerge[adcseq_pkg::S_OVR];
   wire              clr_cerr = bus_wr & hit_stat &
                                wmerge[adcseq_pkg::S_CERR];

   // control fields
   wire              diff_en  = ctrl_r[adcseq_pkg::C_DIFF];
   wire              bip_en   = ctrl_r[adcseq_pkg::C_BIP];
   wire              ext_en   = ctrl_r[adcseq_pkg::C_EXT];
   wire              dyn_en   = ctrl_r[adcseq_pkg::C_DYN];
   wire              trig_en  = ctrl_r[adcseq_pkg::C_TRIG];
   wire [7:0]        pass_max = ctrl_r[adcseq_pkg::C_PASS_LO +: 8];

   // fields of the entry addressed by idx_r
   wire [EW-1:0]     ent      = lst.rdata;
   wire [CW-1:0]     e_ch     = ent[adcseq_pkg::E_CH_LO +: CW];
   wire              e_inh    = ent[adcseq_pkg::E_INH];
   wire [1:0]        e_dyn    = ent[adcseq_pkg::E_DYN_LO +: 2];
   wire              e_ok     = chan_ok(e_ch, diff_en);
   wire              e_dig    = e_ch == adcseq_pkg::DIG_CH;
   wire              c_inh    = cur_r[adcseq_pkg::E_INH];

   // end of list and end of burst
   wire              at_last  = idx_r == last_r;
   wire              pass_end = pass_r == pass_max;
   wire              scanning = (state_r == adcseq_pkg::ST_TICK) ||
                                (state_r == adcseq_pkg::ST_CONV);

   // list memory ports: writes from the bus, reads follow the index
   assign lst.we    = bus_wr & hit_ldat & (&wb_sel_i[1:0]);
   assign lst.waddr = lptr_r;
   assign lst.wdata = wb_dat_i[EW-1:0];
   assign lst.raddr = idx_nxt;

   adcseq_list_ram #(
      .DEPTH (DEPTH)
   ) u_ram (
      .clk_i (clk_i),
      .lst   (lst.ram)
   );

   adcseq_pacer #(
      .DIV_W (DIV_W)
   ) u_pacer (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .run_i     (scanning),
      .ext_sel_i (ext_en),
      .div_i     (div_r),
      .ext_clk_i (ext_clk_i),
      .tick_o    (tick),
      .pace_n_o  (pace_n_o)
   );

   // sequencer: one tick takes one entry, then the index advances
   always_comb begin
      logic adv;
      adv       = 1'b0;
      state_nxt = state_r;
      idx_nxt   = idx_r;
      pass_nxt  = pass_r;
      case (state_r)
         adcseq_pkg::ST_IDLE: begin
            if (cmd_go) begin
               state_nxt = adcseq_pkg::ST_TICK;
               idx_nxt   = '0;
               pass_nxt  = '0;
            end
         end
         adcseq_pkg::ST_TICK: begin
            if (tick) begin
               if (e_ok && !e_dig) begin
                  state_nxt = adcseq_pkg::ST_CONV;
               end else begin
                  adv = 1'b1;
               end
            end
         end
         adcseq_pkg::ST_CONV: begin
            adv = conv_done_i;
         end
         adcseq_pkg::ST_RETRIG: begin
            if (cmd_go) begin
               state_nxt = adcseq_pkg::ST_TICK;
            end
         end
         default: begin
            state_nxt = adcseq_pkg::ST_IDLE;
         end
      endcase
      if (adv) begin
         state_nxt = adcseq_pkg::ST_TICK;
         if (at_last) begin
            idx_nxt = '0;
            if (trig_en) begin
               pass_nxt = pass_end ? 8'h00 : 8'(pass_r + 8'h01);
               if (pass_end) begin
                  state_nxt = adcseq_pkg::ST_RETRIG;
               end
            end
         end else begin
            idx_nxt = LST_W'(idx_r + 1'b1);
         end
      end
      if (cmd_stop) begin
         state_nxt = adcseq_pkg::ST_IDLE;
      end
   end

   // sequencer state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= adcseq_pkg::ST_IDLE;
         run_r   <= 1'b0;
         idx_r   <= '0;
         pass_r  <= '0;
      end else begin
         state_r <= state_nxt;
         run_r   <= state_nxt != adcseq_pkg::ST_IDLE;
         idx_r   <= idx_nxt;
         pass_r  <= pass_nxt;
      end
   end

   // entry capture and converter start
   wire take   = (state_r == adcseq_pkg::ST_TICK) & tick;
   wire go_a2d = take & e_ok & ~e_dig & ~cmd_stop;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_r   <= '0;
         start_r <= 1'b0;
      end else begin
         start_r <= go_a2d;
         if (take) begin
            cur_r <= ent;
         end
      end
   end

   // channel and gain selects come from the entry held for this conversion
   assign conv_start_o = start_r;
   assign conv_chan_o  = cur_r[adcseq_pkg::E_CH_LO +: 5];
   assign conv_gain_o  = cur_r[adcseq_pkg::E_GAIN_LO +: 2];
   assign conv_diff_o  = diff_en;
   assign conv_bip_o   = bip_en;

   // dynamic lines change as the entry is taken; no reset on purpose
   always_ff @(posedge clk_i) begin
      if (take && dyn_en && !cmd_stop) begin
         dyn_r <= e_dyn;
      end
   end
   assign dyn_o = dyn_r;

   // result path: inhibit drops the word after the conversion
   wire dig_keep = take & e_ok & e_dig & ~e_inh;
   wire a2d_keep = (state_r == adcseq_pkg::ST_CONV) & conv_done_i & ~c_inh;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_r <= 1'b0;
         data_r  <= '0;
         chan_r  <= '0;
      end else begin
         valid_r <= dig_keep | a2d_keep;
         if (dig_keep) begin
            data_r <= dio_i;
            chan_r <= adcseq_pkg::DIG_CH;
         end else if (a2d_keep) begin
            data_r <= conv_data_i;
            chan_r <= cur_r[adcseq_pkg::E_CH_LO +: CW];
         end
      end
   end
   assign smp_valid_o = valid_r;
   assign smp_data_o  = data_r;
   assign smp_chan_o  = chan_r;
   assign run_o       = run_r;

   // sticky errors: a tick lost during a conversion, an illegal channel
   wire ovr_set  = (state_r == adcseq_pkg::ST_CONV) & tick & ~conv_done_i;
   wire cerr_set = take & ~e_ok;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovr_r  <= 1'b0;
         cerr_r <= 1'b0;
      end else begin
         // set wins over a clear arriving in the same cycle
         ovr_r  <= ovr_set | (ovr_r & ~clr_ovr);
         cerr_r <= cerr_set | (cerr_r & ~clr_cerr);
      end
   end

   // software registers
   wire [31:0] ctrl_m = merge({16'h0000, ctrl_r}, wb_dat_i, wb_sel_i);
   wire [31:0] last_m = merge({22'h0, last_r}, wb_dat_i, wb_sel_i);
   wire [31:0] div_m  = merge({8'h00, div_r}, wb_dat_i, wb_sel_i);
   wire [31:0] lptr_m = merge({22'h0, lptr_r}, wb_dat_i, wb_sel_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= adcseq_pkg::CTRL_RST;
         last_r <= adcseq_pkg::LAST_RST;
         div_r  <= adcseq_pkg::DIV_RST;
         lptr_r <= '0;
      end else begin
         if (bus_wr && hit_ctrl) begin
            ctrl_r <= ctrl_m[15:0] & adcseq_pkg::CTRL_MASK;
         end
         if (bus_wr && hit_last) begin
            last_r <= last_m[LST_W-1:0];
         end
         if (bus_wr && hit_div) begin
            div_r <= div_m[DIV_W-1:0];
         end
         // pointer steps after each list word so a burst fills in order
         if (bus_wr && hit_lptr) begin
            lptr_r <= lptr_m[LST_W-1:0];
         end else if (lst.we) begin
            lptr_r <= LST_W'(lptr_r + 1'b1);
         end
      end
   end

   // read selection; list data and command read as zero
   wire [31:0] stat_v = {6'h00, idx_r, 12'h000, cerr_r, ovr_r,
                         state_r == adcseq_pkg::ST_RETRIG, run_o};
   wire [31:0] rd_mux =
      hit_ctrl ? {16'h0000, ctrl_r} :
      hit_last ? {22'h0, last_r} :
      hit_div  ? {8'h00, div_r} :
      hit_lptr ? {22'h0, lptr_r} :
      hit_stat ? stat_v :
      hit_smp  ? {10'h000, chan_r, data_r} :
                 32'h0000_0000;

   // one-cycle ack after each request, unmapped words answer too
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= '0;
      end else begin
         ack_r <= bus_req;
         if (bus_req) begin
            dat_r <= rd_mux;
         end
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
endmodule : adcseq_top

// ==== dv/adcseq_monitor.sv ====
// Purpose: port checks of the channel list sequencer
// Assumes: one clock, sync active-high reset
// Notes:   internal tick is not visible, so pacing is checked loosely
`timescale 1ns/1ps
module adcseq_monitor (
   // clock, reset and bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   // converter, pins and stream
   input wire logic        conv_start_o,
   input wire logic [4:0]  conv_chan_o,
   input wire logic        conv_diff_o,
   input wire logic [15:0] conv_data_i,
   input wire logic        conv_done_i,
   input wire logic [15:0] dio_i,
   input wire logic        pace_n_o,
   input wire logic [1:0]  dyn_o,
   input wire logic        smp_valid_o,
   input wire logic [15:0] smp_data_o,
   input wire logic [5:0]  smp_chan_o,
   input wire logic        run_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a bus request is answered next cycle, for one cycle only
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack; s_req |=> s_ack; endproperty
   a_ack:
      assert property (p_ack) else $error("bus answer timing wrong");
   property p_start; conv_start_o |=> !conv_start_o; endproperty
   a_start:
      assert property (p_start) else $error("start pulse too long");
   property p_valid; smp_valid_o |=> !smp_valid_o; endproperty
   a_valid:
      assert property (p_valid) else $error("sample pulse too long");
   property p_chan;
      conv_start_o && conv_diff_o |-> conv_chan_o <= 5'h0f;
   endproperty
   a_chan:
      assert property (p_chan) else $error("differential channel too big");
   property p_ana;
      smp_valid_o && smp_chan_o != 6'h20
         |-> $past(conv_done_i) && smp_data_o == $past(conv_data_i);
   endproperty
   a_ana:
      assert property (p_ana) else $error("analog sample not the result");
   property p_dig;
      smp_valid_o && smp_chan_o == 6'h20 |-> smp_data_o == $past(dio_i);
   endproperty
   a_dig:
      assert property (p_dig) else $error("digital sample wrong");
   // two idle cycles guard against a stop landing on a tick
   property p_idle;
      !run_o && !$past(run_o) |-> pace_n_o && !conv_start_o;
   endproperty
   a_idle:
      assert property (p_idle) else $error("activity while idle");
   property p_dyn; $changed(dyn_o) |-> run_o && $past(run_o); endproperty
   a_dyn:
      assert property (p_dyn) else $error("dynamic outputs moved idle");
   property p_rst;
      $fell(rst_i) |-> !run_o && pace_n_o && !wb_ack_o && !smp_valid_o;
   endproperty
   a_rst:
      assert property (p_rst) else $error("outputs not reset");
endmodule : adcseq_monitor

// ==== dv/adcseq_conv_model.sv ====
// Purpose: behavioural converter facing the sequencer
// Assumes: one start at a time, answer LAT cycles later
// Notes:   the result encodes the request so the bench can predict it
`timescale 1ns/1ps
module adcseq_conv_model #(
   parameter int LAT = 3
) (
   // clock and request
   input  wire logic       clk_i,
   input  wire logic       start_i,
   input  wire logic [4:0] chan_i,
   input  wire logic [1:0] gain_i,
   input  wire logic       diff_i,
   input  wire logic       bip_i,
   // answer
   output logic [15:0]     data_o = 16'h0,
   output logic            done_o = 1'b0
);
   logic [3:0]  cnt_r = 4'h0;
   logic [15:0] res_r = 16'h0;
   // data toggles outside the done cycle, so a stale result shows every other cycle
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      data_o <= ~data_o;
      if (start_i) begin
         cnt_r <= 4'(LAT);
         res_r <= {6'h2a, bip_i, diff_i, gain_i, 1'b0, chan_i};
      end else if (cnt_r == 4'h1) begin
         done_o <= 1'b1;
         data_o <= res_r;
         cnt_r  <= 4'h0;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule : adcseq_conv_model

// ==== dv/tb_adc_channel_list_sequencer.sv ====
// Purpose: self-checking bench of the channel list sequencer
// Assumes: converter model answers a few cycles after each start
// Notes:   expected samples come from the entry table, not the design
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_adc_channel_list_sequencer;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic        ext = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] rd, dat_o;
   logic        ack, start, done, diff, bip, valid, run, pace_n;
   logic [4:0]  chan;
   logic [1:0]  gain, dyn;
   logic [15:0] cdata, sdata;
   logic [5:0]  schan;
   logic [2:0]  ecnt = 3'h0;
   logic [23:0] got_q[$], exp_q[$];
   int          error_cnt = 0;
   int          n_checks = 0;
   localparam logic [15:0] DIO = 16'ha5c3;
   // register rows: offset beside reset read value, last one unmapped
   logic [7:0]  r_adr[6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h1c, 8'h20};
   logic [31:0] r_exp[6] = '{32'h0, 32'h0, 32'h14, 32'h0, 32'h0, 32'h0};
   // list rows: ch5, ch6 inhibited, digital with gain 1, ch5 again
   logic [10:0] ent[4] = '{11'h445, 11'h106, 11'h220, 11'h6c5};
   adcseq_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .conv_start_o(start), .conv_chan_o(chan), .conv_gain_o(gain),
      .conv_diff_o(diff), .conv_bip_o(bip), .conv_data_i(cdata),
      .conv_done_i(done), .dio_i(DIO), .ext_clk_i(ext),
      .pace_n_o(pace_n), .dyn_o(dyn), .smp_valid_o(valid),
      .smp_data_o(sdata), .smp_chan_o(schan), .run_o(run));
   adcseq_conv_model cm_u (.clk_i(clk_i), .start_i(start), .chan_i(chan),
      .gain_i(gain), .diff_i(diff), .bip_i(bip), .data_o(cdata),
      .done_o(done));
   // 10 MHz clock
   always #50 clk_i = ~clk_i;
   // free running external sample clock, eight cycles a period
   always @(posedge clk_i) begin
      ecnt <= ecnt + 3'h1;
      ext  <= ecnt[2];
   end
   // record each kept sample with the dynamic outputs beside it
   always @(posedge clk_i) begin
      if (valid === 1'b1) got_q.push_back({dyn, schan, sdata});
   end
   function automatic logic [23:0] expv(logic [10:0] e, logic b, logic d,
                                        logic [1:0] y);
      if (e[5:0] == 6'h20) return {y, 6'h20, DIO};
      return {y, e[5:0], 6'h2a, b, d, e[7:6], 1'b0, e[4:0]};
   endfunction : expv
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict
   task automatic timeout();
      error_cnt++;
      print_verdict();
   endtask : timeout
   // one classic cycle; request held until ack is seen at an edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) timeout();
      @(posedge clk_i);
   endtask : wb
   task automatic wait_q(input int n);
      int k;
      k = 0;
      while (got_q.size() < n && k < 300) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 300) timeout();
   endtask : wait_q
   task automatic cmp_q();
      `CHK(got_q.size(), exp_q.size())
      foreach (exp_q[i]) `CHK(got_q[i], exp_q[i])
      got_q.delete();
      exp_q.delete();
   endtask : cmp_q
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (r_adr[i]) begin
         wb(1'b0, r_adr[i], 32'h0);
         `CHK(rd, r_exp[i])
      end
      `CHK(dyn, 2'b00)
      $display("test reset values done");
      // bipolar triggered scan, two passes, dynamic outputs on
      wb(1'b1, 8'h0c, 32'h0);
      foreach (ent[i]) begin
         wb(1'b1, 8'h10, {21'h0, ent[i]});
         if (!ent[i][8]) exp_q.push_back(expv(ent[i], 1, 0, ent[i][10:9]));
      end
      exp_q = {exp_q, exp_q};
      wb(1'b1, 8'h04, 32'h3);
      wb(1'b1, 8'h00, 32'h11a);
      wb(1'b1, 8'h1c, 32'h1);
      wait_q(6);
      repeat (40) @(posedge clk_i);
      cmp_q();
      wb(1'b0, 8'h14, 32'h0);
      `CHK(rd[1:0], 2'b11)
      `CHK(dyn, 2'b11)
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      `CHK(dyn, 2'b11)
      `CHK(run, 1'b0)
      $display("test triggered scan done");
      // differential continuous scan on the external clock
      wb(1'b1, 8'h0c, 32'h0);
      wb(1'b1, 8'h10, 32'h00f);
      wb(1'b1, 8'h10, 32'h014);
      wb(1'b1, 8'h04, 32'h1);
      wb(1'b1, 8'h00, 32'h5);
      wb(1'b1, 8'h1c, 32'h1);
      repeat (3) exp_q.push_back(expv(11'h00f, 0, 1, 2'b11));
      wait_q(3);
      wb(1'b1, 8'h1c, 32'h2);
      wb(1'b0, 8'h14, 32'h0);
      `CHK(rd[3], 1'b1)
      `CHK(run, 1'b0)
      repeat (20) @(posedge clk_i);
      cmp_q();
      $display("test continuous scan done");
      print_verdict();
   end
endmodule : tb_adc_channel_list_sequencer
bind adcseq_top adcseq_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
   .conv_diff_o(conv_diff_o), .conv_data_i(conv_data_i),
   .conv_done_i(conv_done_i), .dio_i(dio_i), .pace_n_o(pace_n_o),
   .dyn_o(dyn_o), .smp_valid_o(smp_valid_o), .smp_data_o(smp_data_o),
   .smp_chan_o(smp_chan_o), .run_o(run_o));
